/* gpib_remote_local_trigger.sv */
// Functional notes
// [RULE1] clear abandons any transfer in progress
// [RULE2] selected clear needs listen; device clear always
// [RULE3] trigger acted on only remote and listening
// [RULE4] trigger settings: ignore, immediate, delayed
// [RULE5] delayed trigger response after reset
// [RULE6] remote enable arms; listen address enters remote
// [RULE7] remote/local moves keep all settings
// [RULE8] remote indicator follows remote state
// [RULE9] go-local returns to panel, lockout stays latched
// [RULE10] latched lockout reapplies; only enable drop clears
// [RULE11] listen and talk indicators follow addressing
// [RULE12] lockout in remote disables local key
// [RULE13] lockout in local arms remote with lockout
// [RULE14] local key cannot release lockout
// [RULE15] enable drop: local, lockout cleared, indicator off
// [RULE16] take-control command ignored
// [RULE17] range code 01-05 manual, 11-15 auto
// [RULE18] filter code 00-09 manual, 10-19 auto
// [RULE19] limit result 0 in, 1 over, 2 under
// [RULE20] units 0 watts, 1 dbm, 2 percent, 3 db
// [RULE21] mode, trigger and flag digits in report
// [RULE22] 26 characters, cr, lf, eoi on last
// [RULE23] listener stays until talk, abort or unlisten
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module gpib_remote_local_trigger (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // bus lines and front panel, asynchronous
  input wire logic ren_i,
  input wire logic ifc_i,
  input wire logic local_key_i,
  // decoded bus commands from the interface front end
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic status_report_request_i,
  // talker byte stream
  output logic [7:0] tx_data_o,
  output logic tx_eoi_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // indicators and actions
  output logic remote_indicator_o,
  output logic listener_indicator_o,
  output logic talker_indicator_o,
  output logic local_key_enable_o,
  output logic xfer_abort_o,
  output logic immediate_measure_action_o,
  output logic settled_measure_action_o
);

  typedef struct packed {
    gpib_rlt_pkg::rl_state_t fsm;
    logic llo;
    logic listen;
    logic talk;
    logic remote_indicator;
    logic key_en;
    logic key_prev;
    logic abort;
    logic imm;
    logic settled;
    logic pend;
    logic tx_valid;
    logic tx_eoi;
    logic [7:0] tx_data;
    logic [4:0] idx;
    logic [1:0] trig_set;
    logic [31:0] fields;
    logic [31:0] flags;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } top_st_t;

  top_st_t q;
  top_st_t d;

  logic [2:0] pins_s;
  logic ren_s;
  logic ifc_s;
  logic key_s;
  gpib_rlt_pkg::bus_cmd_t cmd;
  logic setup;
  logic wr_acc;
  logic mapped;
  logic clear;
  logic hs;
  logic [31:0] wmask;

  report_if rpt ();

  pin_sync #(
    .W(3)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i({local_key_i, ifc_i, ren_i}),
    .level_o(pins_s)
  );

  report_char_fmt u_fmt (
    .rpt(rpt.fmt)
  );

  assign ren_s = pins_s[0];
  assign ifc_s = pins_s[1];
  assign key_s = pins_s[2];

  assign rpt.fields = gpib_rlt_pkg::fields_reg_t'(q.fields);
  assign rpt.flags = gpib_rlt_pkg::flags_reg_t'(q.flags);
  assign rpt.trig_set = q.trig_set;
  // the formatter looks ahead at the byte to load next
  assign hs = q.tx_valid & tx_ready_i;
  assign rpt.idx = hs ? q.idx + 5'h01 : 5'h00;

  always_comb begin
    cmd = gpib_rlt_pkg::CMD_NONE;
    if (cmd_valid_i) begin
      cmd = gpib_rlt_pkg::bus_cmd_t'(cmd_code_i);
    end
  end

  assign setup = psel_i & ~penable_i;
  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign mapped = (paddr_i == gpib_rlt_pkg::ADDR_CTRL) ||
                  (paddr_i == gpib_rlt_pkg::ADDR_FIELDS) ||
                  (paddr_i == gpib_rlt_pkg::ADDR_FLAGS) ||
                  (paddr_i == gpib_rlt_pkg::ADDR_STATUS);

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{pstrb_i[b]}};
    end
  end

  // selected clear counts only while listening, device clear always
  assign clear = (cmd == gpib_rlt_pkg::CMD_DEV_CLEAR) ||
                 (cmd == gpib_rlt_pkg::CMD_SEL_CLEAR && q.listen); // RULE2

  always_comb begin
    d = q;
    d.abort = 1'b0;
    d.imm = 1'b0;
    d.settled = 1'b0;
    d.key_prev = key_s;

    // addressing; abort clears both roles
    case (cmd)
      gpib_rlt_pkg::CMD_MY_LISTEN: begin
        d.listen = 1'b1;
        d.talk = 1'b0;
      end
      gpib_rlt_pkg::CMD_MY_TALK: begin
        d.talk = 1'b1;
        d.listen = 1'b0; // RULE23
      end
      gpib_rlt_pkg::CMD_UNLISTEN: d.listen = 1'b0; // RULE23
      gpib_rlt_pkg::CMD_UNTALK: d.talk = 1'b0;
      default: d.listen = q.listen;
    endcase
    if (ifc_s) begin
      d.listen = 1'b0; // RULE23
      d.talk = 1'b0;
    end

    // lockout latch: set by the command while enabled
    if (cmd == gpib_rlt_pkg::CMD_LOCKOUT && ren_s) begin
      d.llo = 1'b1; // RULE13
    end

    // fsm touches only mode state, never the setting registers
    case (q.fsm) // RULE7
      gpib_rlt_pkg::FSM_LOCAL, gpib_rlt_pkg::FSM_LOCAL_LOCK: begin
        if (ren_s && cmd == gpib_rlt_pkg::CMD_MY_LISTEN) begin
          d.fsm = d.llo ? gpib_rlt_pkg::FSM_REMOTE_LOCK // RULE10
                        : gpib_rlt_pkg::FSM_REMOTE; // RULE6
        end else if (d.llo) begin
          d.fsm = gpib_rlt_pkg::FSM_LOCAL_LOCK; // RULE13
        end
      end
      gpib_rlt_pkg::FSM_REMOTE: begin
        if (cmd == gpib_rlt_pkg::CMD_LOCKOUT) begin
          d.fsm = gpib_rlt_pkg::FSM_REMOTE_LOCK; // RULE12
        end else if (cmd == gpib_rlt_pkg::CMD_GO_LOCAL && q.listen) begin
          d.fsm = gpib_rlt_pkg::FSM_LOCAL; // RULE9
        end else if (key_s && !q.key_prev) begin
          d.fsm = gpib_rlt_pkg::FSM_LOCAL;
        end
      end
      gpib_rlt_pkg::FSM_REMOTE_LOCK: begin
        // panel key is not looked at here
        if (cmd == gpib_rlt_pkg::CMD_GO_LOCAL && q.listen) begin
          d.fsm = gpib_rlt_pkg::FSM_LOCAL_LOCK; // RULE9 RULE14
        end
      end
      default: d.fsm = gpib_rlt_pkg::FSM_LOCAL;
    endcase

    // losing enable overrides everything else
    if (!ren_s) begin
      d.fsm = gpib_rlt_pkg::FSM_LOCAL; // RULE15 RULE14
      d.llo = 1'b0; // RULE10 RULE15
    end

    d.remote_indicator = (d.fsm == gpib_rlt_pkg::FSM_REMOTE) ||
            (d.fsm == gpib_rlt_pkg::FSM_REMOTE_LOCK); // RULE8
    d.key_en = (d.fsm != gpib_rlt_pkg::FSM_REMOTE_LOCK); // RULE12 RULE14

    // trigger dispatch; take-control falls through untouched
    if (cmd == gpib_rlt_pkg::CMD_GROUP_TRIG && q.remote_indicator && q.listen) begin // RULE3
      case (q.trig_set) // RULE4
        gpib_rlt_pkg::TRIGGER_IGNORE_SETTING: d.imm = 1'b0;
        gpib_rlt_pkg::TRIGGER_IMMEDIATE_SETTING: d.imm = 1'b1;
        default: d.settled = 1'b1; // RULE5
      endcase
    end // RULE16

    // status report talker; a new request beats a same-cycle clear
    if (clear) begin
      d.abort = 1'b1; // RULE1
    end
    if (hs && q.idx == gpib_rlt_pkg::REPORT_LAST) begin
      d.tx_valid = 1'b0;
      d.tx_eoi = 1'b0;
      d.pend = 1'b0;
    end else if (hs) begin
      d.idx = q.idx + 5'h01;
      d.tx_data = rpt.chr;
      d.tx_eoi = (d.idx == gpib_rlt_pkg::REPORT_LAST); // RULE22
    end else if (!q.tx_valid && q.pend && q.talk && !clear) begin
      d.idx = 5'h00;
      d.tx_data = rpt.chr;
      d.tx_valid = 1'b1;
      d.tx_eoi = 1'b0;
    end
    if (clear || ifc_s || !d.talk) begin
      d.tx_valid = 1'b0; // RULE1
      d.tx_eoi = 1'b0;
    end
    if (clear) begin
      d.pend = 1'b0; // RULE1
    end
    if (status_report_request_i) begin
      d.pend = 1'b1;
    end

    // apb: read data captured in setup, zero-wait access
    d.pready = 1'b1;
    if (setup) begin
      d.pslverr = ~mapped;
      case (paddr_i)
        gpib_rlt_pkg::ADDR_CTRL: d.prdata = {30'h0, q.trig_set};
        gpib_rlt_pkg::ADDR_FIELDS: d.prdata = q.fields;
        gpib_rlt_pkg::ADDR_FLAGS: d.prdata = q.flags;
        gpib_rlt_pkg::ADDR_STATUS: d.prdata = {24'h0, q.pend, q.tx_valid,
                                               ~q.key_en, q.llo, q.talk,
                                               q.listen, ren_s, q.remote_indicator};
        default: d.prdata = 32'h0000_0000;
      endcase
    end
    if (wr_acc && pstrb_i[0] && paddr_i == gpib_rlt_pkg::ADDR_CTRL) begin
      d.trig_set = pwdata_i[1:0]; // RULE4
    end
    if (wr_acc && paddr_i == gpib_rlt_pkg::ADDR_FIELDS) begin
      d.fields = (q.fields & ~wmask) | (pwdata_i & wmask);
      d.fields[31:27] = 5'h00;
    end
    if (wr_acc && paddr_i == gpib_rlt_pkg::ADDR_FLAGS) begin
      d.flags = (q.flags & ~wmask) | (pwdata_i & wmask);
      d.flags[31:11] = 21'h000000;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.fsm <= gpib_rlt_pkg::FSM_LOCAL;
      q.key_en <= 1'b1;
      q.trig_set <= gpib_rlt_pkg::CTRL_RESET; // RULE5
      q.fields <= gpib_rlt_pkg::FIELDS_RESET;
      q.flags <= gpib_rlt_pkg::FLAGS_RESET;
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign tx_data_o = q.tx_data;
  assign tx_eoi_o = q.tx_eoi;
  assign tx_valid_o = q.tx_valid;
  assign remote_indicator_o = q.remote_indicator; // RULE8
  assign listener_indicator_o = q.listen; // RULE11
  assign talker_indicator_o = q.talk; // RULE11
  assign local_key_enable_o = q.key_en;
  assign xfer_abort_o = q.abort;
  assign immediate_measure_action_o = q.imm;
  assign settled_measure_action_o = q.settled;

endmodule // gpib_remote_local_trigger

/* gpib_rlt_pkg.sv */
package gpib_rlt_pkg;

  // apb register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FIELDS = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // trigger response selection, ctrl bits [1:0]
  localparam logic [1:0] TRIGGER_IGNORE_SETTING = 2'h0;
  localparam logic [1:0] TRIGGER_IMMEDIATE_SETTING = 2'h1;
  localparam logic [1:0] TRIGGER_DELAYED_SETTING = 2'h2;
  localparam logic [1:0] CTRL_RESET = TRIGGER_DELAYED_SETTING;

  // operating mode field codes
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [1:0] OPM_ZEROING = 2'h1;
  localparam logic [1:0] OPM_CALIBRATION = 2'h2;

  // report field layout, bit 0 upward from the last member
  typedef struct packed {
    logic [4:0] rsvd;
    logic auto_filter;
    logic [3:0] filter_exp;
    logic auto_range;
    logic [2:0] range_sel;
    logic [1:0] op_mode;
    logic [7:0] entry_err_bcd;
    logic [7:0] meas_err_bcd;
  } fields_reg_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic [1:0] units;
    logic duty_on;
    logic offset_on;
    logic [1:0] limit_result;
    logic limit_check_on;
    logic trig_standby;
    logic rel_on;
    logic pwr_ref_on;
    logic log_scale;
  } flags_reg_t;

  localparam logic [31:0] FIELDS_RESET = 32'h0004_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

  // report characters
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_SIX = 8'h36;
  localparam logic [7:0] CHR_EIGHT = 8'h38;
  localparam logic [7:0] CHR_A = 8'h41;
  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_LF = 8'h0a;
  localparam logic [4:0] REPORT_CHARS = 5'h1a;
  localparam logic [4:0] REPORT_LAST = 5'h1b;

  typedef enum logic [3:0] {
    FSM_LOCAL = 4'b0001,
    FSM_REMOTE = 4'b0010,
    FSM_LOCAL_LOCK = 4'b0100,
    FSM_REMOTE_LOCK = 4'b1000
  } rl_state_t;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_MY_LISTEN = 4'h1,
    CMD_MY_TALK = 4'h2,
    CMD_UNLISTEN = 4'h3,
    CMD_UNTALK = 4'h4,
    CMD_SEL_CLEAR = 4'h5,
    CMD_DEV_CLEAR = 4'h6,
    CMD_GROUP_TRIG = 4'h7,
    CMD_GO_LOCAL = 4'h8,
    CMD_LOCKOUT = 4'h9,
    CMD_TAKE_CTRL = 4'ha
  } bus_cmd_t;

endpackage

/* report_if.sv */
`timescale 1ns/1ns
interface report_if;
  gpib_rlt_pkg::fields_reg_t fields;
  gpib_rlt_pkg::flags_reg_t flags;
  logic [1:0] trig_set;
  logic [4:0] idx;
  logic [7:0] chr;
  modport fmt (input fields, input flags, input trig_set, input idx,
               output chr);
  modport src (output fields, output flags, output trig_set, output idx,
               input chr);
endinterface

/* pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 3
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_st_t;

  sync_st_t q;
  sync_st_t d;

  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // a change is believed only once the two later stages agree
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_o = q.lvl;
endmodule // pin_sync

/* report_char_fmt.sv */
`timescale 1ns/1ns
module report_char_fmt (
  report_if.fmt rpt
);
  function automatic logic [7:0] dig(input logic [3:0] v);
    return gpib_rlt_pkg::CHR_ZERO + {4'h0, v};
  endfunction

  always_comb begin
    rpt.chr = gpib_rlt_pkg::CHR_ZERO;
    case (rpt.idx)
      5'h00: rpt.chr = dig(rpt.fields.meas_err_bcd[7:4]);
      5'h01: rpt.chr = dig(rpt.fields.meas_err_bcd[3:0]);
      5'h02: rpt.chr = dig(rpt.fields.entry_err_bcd[7:4]);
      5'h03: rpt.chr = dig(rpt.fields.entry_err_bcd[3:0]);
      5'h05: begin
        case (rpt.fields.op_mode) // RULE21
          gpib_rlt_pkg::OPM_ZEROING: rpt.chr = gpib_rlt_pkg::CHR_SIX;
          gpib_rlt_pkg::OPM_CALIBRATION: rpt.chr = gpib_rlt_pkg::CHR_EIGHT;
          default: rpt.chr = gpib_rlt_pkg::CHR_ZERO;
        endcase
      end
      5'h06: rpt.chr = dig({3'h0, rpt.fields.auto_range}); // RULE17
      5'h07: rpt.chr = dig({1'h0, rpt.fields.range_sel}); // RULE17
      5'h0a: rpt.chr = dig({3'h0, rpt.fields.auto_filter}); // RULE18
      5'h0b: rpt.chr = dig(rpt.fields.filter_exp); // RULE18
      5'h0e: rpt.chr = dig({3'h0, rpt.flags.log_scale}); // RULE21
      5'h0f: rpt.chr = gpib_rlt_pkg::CHR_A;
      5'h10: rpt.chr = dig({3'h0, rpt.flags.pwr_ref_on}); // RULE21
      5'h11: rpt.chr = dig({3'h0, rpt.flags.rel_on}); // RULE21
      5'h12: rpt.chr = dig({3'h0, rpt.flags.trig_standby}); // RULE21
      5'h13: rpt.chr = dig({2'h0, rpt.trig_set}); // RULE21
      5'h14: rpt.chr = dig({3'h0, rpt.flags.limit_check_on}); // RULE21
      5'h15: rpt.chr = dig({2'h0, rpt.flags.limit_result}); // RULE19
      5'h17: rpt.chr = dig({3'h0, rpt.flags.offset_on}); // RULE21
      5'h18: rpt.chr = dig({3'h0, rpt.flags.duty_on}); // RULE21
      5'h19: rpt.chr = dig({2'h0, rpt.flags.units}); // RULE20
      5'h1a: rpt.chr = gpib_rlt_pkg::CHR_CR; // RULE22
      5'h1b: rpt.chr = gpib_rlt_pkg::CHR_LF; // RULE22
      default: rpt.chr = gpib_rlt_pkg::CHR_ZERO;
    endcase
  end
endmodule // report_char_fmt

/* gpib_rlt_properties.sv */
`timescale 1ns/1ns
module gpib_rlt_properties (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic ren_i,
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_eoi_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic remote_indicator_o,
  input wire logic listener_indicator_o,
  input wire logic talker_indicator_o,
  input wire logic local_key_enable_o,
  input wire logic xfer_abort_o,
  input wire logic settled_measure_action_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [3:0] ren_low_q;
  // ren passes a pin sync, so only a long low stretch must show as local
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || ren_i) begin
      ren_low_q <= 4'h0;
    end else if (ren_low_q != 4'hf) begin
      ren_low_q <= ren_low_q + 4'h1;
    end
  end
  a_apb_zero_wait: assert property (psel_i && !penable_i |=> pready_o)
    else $error("apb access not ready");
  a_unmapped_err: assert property (psel_i && !penable_i |=>
    pslverr_o == !($past(paddr_i) inside {8'h00, 8'h04, 8'h08, 8'h0c}))
    else $error("bad pslverr");
  a_listen_addr: assert property (cmd_valid_i && cmd_code_i == 4'h1 |=>
    listener_indicator_o && !talker_indicator_o) else $error("no listen");
  a_talk_addr: assert property (cmd_valid_i && cmd_code_i == 4'h2 |=>
    talker_indicator_o && !listener_indicator_o) else $error("no talk");
  a_trig_gate: assert property (settled_measure_action_o |-> $past(
    cmd_valid_i && cmd_code_i == 4'h7 && remote_indicator_o &&
    listener_indicator_o)) else $error("trigger not gated");
  a_dev_clear: assert property (cmd_valid_i && cmd_code_i == 4'h6 |=>
    xfer_abort_o) else $error("device clear missed");
  a_take_ctrl: assert property (cmd_valid_i && cmd_code_i == 4'ha |=>
    $stable({remote_indicator_o, listener_indicator_o, talker_indicator_o,
    local_key_enable_o}) && !xfer_abort_o) else $error("take control acted");
  a_ren_drop: assert property (ren_low_q > 4'h6 |->
    !remote_indicator_o && local_key_enable_o) else $error("not local");
  a_lock_remote: assert property (!local_key_enable_o |->
    remote_indicator_o) else $error("key off outside remote");
  a_eoi_last: assert property (tx_valid_o && tx_eoi_o |->
    tx_data_o == 8'h0a) else $error("eoi not on line feed");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
    !tx_valid_o || $stable(tx_data_o)) else $error("byte changed");
endmodule // gpib_rlt_properties
bind gpib_remote_local_trigger gpib_rlt_properties i_gpib_rlt_properties (.*);

/* gpib_ctrl_model.sv */
`timescale 1ns/1ns
module gpib_ctrl_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_eoi_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic ren_o,
  output logic cmd_valid_o,
  output logic [3:0] cmd_code_o
);
  logic [8:0] got[$];
  integer seed = 13;
  initial begin
    tx_ready_o = 1'b0;
    ren_o = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_code_o = 4'h0;
  end
  // listener stalls at random; a byte counts only where valid meets ready
  always @(posedge ref_clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got.push_back({tx_eoi_i, tx_data_i});
    end
    tx_ready_o <= ($random(seed) & 3) != 0;
  end
  // remote needs ren first, addressing after; lockout is left by ren drop
  task set_ren(input logic v);
    @(posedge ref_clk_i);
    ren_o <= v;
  endtask
  // the scope of a clear is chosen by the command code sent
  task send_cmd(input logic [3:0] c);
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= c;
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_code_o <= ~c;
  endtask
endmodule // gpib_ctrl_model

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic ref_clk_i, reset_i, psel_i, penable_i, pwrite_i, ifc_i, key_i, req_i;
  logic [7:0] paddr_i, tx_data;
  logic [31:0] pwdata_i, prdata, rd, f, g;
  logic pready, pslverr, err, tx_eoi, tx_valid, tx_ready, ren, cv;
  logic remote_indicator, listener_indicator, talker_indicator, key_en, abt, imm, setl;
  logic [3:0] code;
  logic [1:0] t;
  int num_errors = 0, samples_checked = 0, n_imm = 0, n_set = 0, n_abt = 0;
  int b_imm, b_set, b_abt, i, k;
  integer seed = 13;
  gpib_remote_local_trigger i_gpib_remote_local_trigger (.ref_clk_i,
    .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ren_i(ren), .ifc_i, .local_key_i(key_i),
    .cmd_valid_i(cv), .cmd_code_i(code), .status_report_request_i(req_i),
    .tx_data_o(tx_data), .tx_eoi_o(tx_eoi), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_ready), .remote_indicator_o(remote_indicator),
    .listener_indicator_o(listener_indicator), .talker_indicator_o(talker_indicator),
    .local_key_enable_o(key_en), .xfer_abort_o(abt),
    .immediate_measure_action_o(imm), .settled_measure_action_o(setl));
  gpib_ctrl_model i_gpib_ctrl_model (.ref_clk_i, .tx_data_i(tx_data),
    .tx_eoi_i(tx_eoi), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .ren_o(ren), .cmd_valid_o(cv), .cmd_code_o(code));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    n_imm <= n_imm + int'(imm);
    n_set <= n_set + int'(setl);
    n_abt <= n_abt + int'(abt);
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task cmd(input logic [3:0] c);
    i_gpib_ctrl_model.send_cmd(c);
    #1;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task pulses(input int ei, es, ea);
    check("immediate", n_imm - b_imm, ei);
    check("settled", n_set - b_set, es);
    check("abort", n_abt - b_abt, ea);
    b_imm = n_imm;
    b_set = n_set;
    b_abt = n_abt;
  endtask
  function automatic int r(input int n);
    return int'($unsigned($random(seed)) % n);
  endfunction
  function automatic logic [7:0] chr(input logic [31:0] f, g,
      input logic [1:0] t, input int k);
    logic [103:0] v;
    logic [3:0] om;
    om = f[17:16] == 2'h0 ? 4'h0 : f[17:16] == 2'h1 ? 4'h6 : 4'h8;
    v = {f[7:4], f[3:0], f[15:12], f[11:8], 4'h0, om, 3'h0, f[21], 1'b0,
      f[20:18], 8'h00, 3'h0, f[26], f[25:22], 8'h00, 3'h0, g[0], 4'h0,
      3'h0, g[1], 3'h0, g[2], 3'h0, g[3], 2'h0, t, 3'h0, g[4], 2'h0,
      g[6:5], 4'h0, 3'h0, g[7], 3'h0, g[8], 2'h0, g[10:9]};
    if (k == 26) return gpib_rlt_pkg::CHR_CR;
    if (k == 27) return gpib_rlt_pkg::CHR_LF;
    if (k == 15) return gpib_rlt_pkg::CHR_A;
    return gpib_rlt_pkg::CHR_ZERO + {4'h0, v[103-4*k -: 4]};
  endfunction
  initial begin
    {psel_i, penable_i, pwrite_i, ifc_i, key_i, req_i} = 6'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    reset_i = 1'b1;
    tick(4);
    reset_i <= 1'b0;
    apb(1'b0, gpib_rlt_pkg::ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, {30'h0, gpib_rlt_pkg::CTRL_RESET});
    apb(1'b0, gpib_rlt_pkg::ADDR_FIELDS, 32'h0);
    check("fields reset", rd, gpib_rlt_pkg::FIELDS_RESET);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    b_imm = n_imm;
    b_set = n_set;
    b_abt = n_abt;
    $display("test reset done");
    i_gpib_ctrl_model.set_ren(1'b1);
    tick(6);
    check("armed only", remote_indicator, 1'b0);
    cmd(4'h1);
    check("remote", {remote_indicator, listener_indicator}, 2'h3);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, gpib_rlt_pkg::ADDR_CTRL, i);
      cmd(4'h7);
      tick(1);
      pulses(i == 1, i >= 2, 0);
    end
    cmd(4'h3);
    cmd(4'h7);
    cmd(4'h5);
    tick(1);
    pulses(0, 0, 0);
    cmd(4'h6);
    cmd(4'h1);
    cmd(4'h5);
    tick(1);
    pulses(0, 0, 2);
    $display("test trigger and clear done");
    apb(1'b1, gpib_rlt_pkg::ADDR_FIELDS, 32'h0676_9999);
    cmd(4'h9);
    check("lockout key", key_en, 1'b0);
    key_i <= 1'b1;
    tick(6);
    key_i <= 1'b0;
    check("key ignored", remote_indicator, 1'b1);
    cmd(4'h8);
    check("go local", {remote_indicator, key_en}, 2'h1);
    cmd(4'h1);
    check("relock", {remote_indicator, key_en}, 2'h2);
    cmd(4'ha);
    check("take ctrl", {remote_indicator, key_en}, 2'h2);
    i_gpib_ctrl_model.set_ren(1'b0);
    tick(6);
    check("ren drop", {remote_indicator, key_en}, 2'h1);
    apb(1'b0, gpib_rlt_pkg::ADDR_FIELDS, 32'h0);
    check("settings kept", rd, 32'h0676_9999);
    i_gpib_ctrl_model.set_ren(1'b1);
    tick(6);
    cmd(4'h1);
    check("latch cleared", {remote_indicator, key_en}, 2'h3);
    cmd(4'h8);
    cmd(4'h9);
    cmd(4'h1);
    check("local lockout", {remote_indicator, key_en}, 2'h2);
    cmd(4'h8);
    cmd(4'h7);
    tick(1);
    pulses(0, 0, 0);
    ifc_i <= 1'b1;
    tick(6);
    ifc_i <= 1'b0;
    check("abort unlistens", listener_indicator, 1'b0);
    tick(6);
    $display("test remote local done");
    for (i = 0; i < 3; i++) begin
      f = i == 0 ? 32'h0676_9999 : {5'h0, 1'(r(2)), 4'(r(10)), 1'(r(2)),
        3'(r(5) + 1), 2'(r(3)), 4'(r(10)), 4'(r(10)), 4'(r(10)), 4'(r(10))};
      g = i == 0 ? 32'h7df : {21'h0, 2'(r(4)), 2'(r(4)), 2'(r(3)), 5'(r(32))};
      if (g[6:5] == 2'h3) g[6:5] = 2'h2;
      t = 2'(r(3));
      apb(1'b1, gpib_rlt_pkg::ADDR_FIELDS, f);
      apb(1'b1, gpib_rlt_pkg::ADDR_FLAGS, g);
      apb(1'b1, gpib_rlt_pkg::ADDR_CTRL, {30'h0, t});
      i_gpib_ctrl_model.got.delete();
      req_i <= 1'b1;
      tick(1);
      req_i <= 1'b0;
      cmd(4'h2);
      for (k = 0; k < 400 && i_gpib_ctrl_model.got.size() < 28; k++) tick(1);
      if (k >= 400) begin
        num_errors++;
        report_and_stop();
      end
      for (k = 0; k < 28; k++) begin
        check("report byte", {23'h0, i_gpib_ctrl_model.got[k]}, {23'h0, k == 27, chr(f, g, t, k)});
      end
      cmd(4'h4);
    end
    $display("test report done");
    report_and_stop();
  end
endmodule // tb_top
